// >>> hdl/dmnc_core.sv
// Map-select and NMI core of a debug monitor board.
// Assumes processor bus signals sampled on core_clk_i (phase-2 rate);
// switches, restart, abort and parity lines are asynchronous pins.
//
// What this block does
// RULE_01: Switch off: access strobe goes to user map
// RULE_02: Single map: F000-FFFF exec, else user
// RULE_03: Dual map: shift output selects user or exec
// RULE_04: Reset forces both map strobes low
// RULE_05: Load strobe edge gives exactly one load
// RULE_06: Shift register loaded from four port bits
// RULE_07: Shift up each cycle, serial flop fills
// RULE_08: Load port access loads register next cycle
// RULE_09: Software presets bit four for user store
// RULE_10: Exec reset clears register and serial flop
// RULE_11: User reset sets the serial flop
// RULE_12: Sixteen-bit address match, map selected by bit
// RULE_13: Scope trigger only with stop-on-match enabled
// RULE_14: Halt-on-match switch raises match interrupt
// RULE_15: Match, abort, parity ack drop NMI at once
// RULE_16: NMI held low for 32 cycles
// RULE_17: Parity enabled: each falling fault gives ack
// RULE_18: Board NMI in dual map forces exec vector
// RULE_19: Step load starts counter, then NMI fires
// RULE_20: Separate origin flags for each NMI source
// RULE_21: Data buffers inputs except on board reads
// RULE_22: Board elements enabled by bus exec strobe
// RULE_23: Restart switch picks user or exec reset
// RULE_24: No shifting during bus grant or float
// RULE_25: Strobe drivers released on float or halt
// RULE_26: Read, seven writes, read detects soft interrupt
// RULE_27: New source does not extend NMI hold
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module dmnc_core #(
  parameter int STEP_DELAY = dmnc_pkg::STEP_DELAY_CYC
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic valid_mem_access_i,
  input wire logic [15:0] addr_i,
  input wire logic rw_i,
  input wire logic bus_grant_ack_i,
  input wire logic bus_float_request_i,
  input wire logic halt_i,
  input wire logic exec_map_bus_i,
  input wire logic [1:0] map_mode_switch_i,
  input wire logic halt_action_switch_i,
  input wire logic restart_target_switch_i,
  input wire logic restart_i,
  input wire logic abort_i,
  input wire logic parity_fault_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic user_map_strobe_o,
  output logic exec_map_strobe_o,
  output logic map_strobe_oe_o,
  output logic nmi_n_o,
  output logic scope_trigger_o,
  output logic abort_flag_line_o,
  output logic match_flag_line_o,
  output logic step_flag_line_o,
  output logic board_select_o,
  output logic data_buf_in_o,
  output logic exec_reset_o,
  output logic user_reset_o
);
  logic [dmnc_pkg::PIN_W-1:0] pin_raw;
  logic [dmnc_pkg::PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
  logic restart_prev_q, abort_prev_q, parity_prev_q;
  logic exec_rst_q, user_rst_q, any_rst;
  logic [15:0] match_addr_q;
  logic [dmnc_pkg::CTRL_W-1:0] ctrl_q;
  logic [3:0] load_data_q;
  logic ld_stb_q, ld_cap_q, ld_pulse, shift_en;
  logic [dmnc_pkg::SR_W-1:0] sr_q, sr_load;
  logic serial_q, shift_out_map_select, force_exec_q;
  dmnc_pkg::dmnc_mode_t mode;
  logic match_hit, stop_on_match_irq, abort_rise, parity_fault_ack;
  logic step_fire, nmi_src, nmi_start;
  logic [5:0] nmi_cnt_q;
  logic [7:0] step_cnt_q;
  logic [3:0] swi_cnt_q;
  logic swi_detect, vec_fetch;
  logic parity_flag_q;
  logic st_rd;

  // Decode the map-mode switch; unknown codes fall back to off
  function automatic dmnc_pkg::dmnc_mode_t mode_of(input logic [1:0] sw);
    dmnc_pkg::dmnc_mode_t m;
    m = dmnc_pkg::MODE_OUT;
    if (sw == dmnc_pkg::SW_SINGLE) begin
      m = dmnc_pkg::MODE_SINGLE;
    end else if (sw == dmnc_pkg::SW_DUAL) begin
      m = dmnc_pkg::MODE_DUAL;
    end
    return m;
  endfunction

  assign pin_raw = {map_mode_switch_i, halt_action_switch_i,
                    parity_fault_n_i, abort_i, restart_i};

  // Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s1_q <= dmnc_pkg::PIN_RST;
      s2_q <= dmnc_pkg::PIN_RST;
      s3_q <= dmnc_pkg::PIN_RST;
      pin_q <= dmnc_pkg::PIN_RST;
    end else if (clk_en_i) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < dmnc_pkg::PIN_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign mode = mode_of(pin_q[dmnc_pkg::PIN_MODE +: 2]);

  // Edge history of the cleaned pins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      restart_prev_q <= 1'b0;
      abort_prev_q <= 1'b0;
      parity_prev_q <= 1'b1;
    end else if (clk_en_i) begin
      restart_prev_q <= pin_q[dmnc_pkg::PIN_RESTART];
      abort_prev_q <= pin_q[dmnc_pkg::PIN_ABORT];
      parity_prev_q <= pin_q[dmnc_pkg::PIN_PARITY_N];
    end
  end

  // Front-panel restart becomes a one-cycle user or exec reset
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      exec_rst_q <= 1'b0;
      user_rst_q <= 1'b0;
    end else if (clk_en_i) begin
      exec_rst_q <= pin_q[dmnc_pkg::PIN_RESTART] & ~restart_prev_q
                    & ~restart_target_switch_i; // [RULE_23]
      user_rst_q <= pin_q[dmnc_pkg::PIN_RESTART] & ~restart_prev_q
                    & restart_target_switch_i; // [RULE_23]
    end
  end
  assign exec_reset_o = exec_rst_q;
  assign user_reset_o = user_rst_q;
  assign any_rst = srst_i | exec_rst_q | user_rst_q;

  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      match_addr_q <= dmnc_pkg::MATCH_RST;
      ctrl_q <= dmnc_pkg::CTRL_RST;
      load_data_q <= dmnc_pkg::LOAD_RST;
    end else if (clk_en_i && reg_wr_i) begin
      unique case (reg_addr_i)
        dmnc_pkg::REG_MATCH_ADDR: match_addr_q <= reg_wdata_i;
        dmnc_pkg::REG_CTRL: ctrl_q <= reg_wdata_i[dmnc_pkg::CTRL_W-1:0];
        dmnc_pkg::REG_LOAD: load_data_q <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // Load strobe: any access to the load port; capture flop makes one pulse
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ld_stb_q <= 1'b0;
      ld_cap_q <= 1'b0;
    end else if (clk_en_i) begin
      ld_stb_q <= (reg_wr_i | reg_rd_i)
                  & (reg_addr_i == dmnc_pkg::REG_LOAD); // [RULE_08]
      ld_cap_q <= ld_stb_q; // [RULE_05]
    end
  end
  assign ld_pulse = ld_stb_q & ~ld_cap_q; // [RULE_05]

  // Shifting pauses while the bus is granted away or floated
  assign shift_en = ~bus_grant_ack_i & ~bus_float_request_i; // [RULE_24]

  // Four loadable positions; the rest load as zero
  always_comb begin
    sr_load = '0;
    sr_load[dmnc_pkg::LD_POS_BIT4] = load_data_q[3]; // [RULE_06]
    sr_load[dmnc_pkg::LD_POS_BIT0] = load_data_q[0]; // [RULE_06]
    sr_load[dmnc_pkg::LD_POS_BIT1] = load_data_q[1]; // [RULE_06]
    sr_load[dmnc_pkg::LD_POS_BIT2] = load_data_q[2]; // [RULE_06]
  end

  // Map shift register; an NMI start in dual map also clears it
  always_ff @(posedge core_clk_i) begin
    if (srst_i || exec_rst_q) begin
      sr_q <= '0; // [RULE_10]
    end else if (clk_en_i) begin
      if (ld_pulse) begin
        sr_q <= sr_load; // [RULE_06] [RULE_08]
      end else if (nmi_start && mode == dmnc_pkg::MODE_DUAL) begin
        sr_q <= '0; // [RULE_18]
      end else if (shift_en) begin
        sr_q <= {sr_q[dmnc_pkg::SR_W-2:0], serial_q}; // [RULE_07]
      end
    end
  end
  assign shift_out_map_select = sr_q[dmnc_pkg::SR_W-1];

  // Serial input flop, set or cleared only by the three resets
  always_ff @(posedge core_clk_i) begin
    if (srst_i || exec_rst_q) begin
      serial_q <= 1'b0; // [RULE_10]
    end else if (clk_en_i && user_rst_q) begin
      serial_q <= 1'b1; // [RULE_11]
    end
  end

  // Map steering of the access strobe
  always_comb begin
    user_map_strobe_o = 1'b0;
    exec_map_strobe_o = 1'b0;
    if (!any_rst) begin // [RULE_04]
      unique case (mode)
        dmnc_pkg::MODE_OUT: begin
          user_map_strobe_o = valid_mem_access_i; // [RULE_01]
        end
        dmnc_pkg::MODE_SINGLE: begin
          if (addr_i >= dmnc_pkg::EXEC_LO) begin
            exec_map_strobe_o = valid_mem_access_i; // [RULE_02]
          end else begin
            user_map_strobe_o = valid_mem_access_i; // [RULE_02]
          end
        end
        dmnc_pkg::MODE_DUAL: begin
          if (shift_out_map_select && !force_exec_q) begin
            user_map_strobe_o = valid_mem_access_i; // [RULE_03]
          end else begin
            exec_map_strobe_o = valid_mem_access_i; // [RULE_03] [RULE_18]
          end
        end
      endcase
    end
  end
  // Let another module own the strobes while floated or halted
  assign map_strobe_oe_o = ~bus_float_request_i & ~halt_i; // [RULE_25]

  // On-board elements answer only the exec strobe seen on the bus
  assign board_select_o = exec_map_bus_i
                          & (addr_i >= dmnc_pkg::BOARD_LO); // [RULE_22]
  assign data_buf_in_o = ~(board_select_o & rw_i); // [RULE_21]

  // Address match and stop-on-match request
  assign match_hit = valid_mem_access_i & (addr_i == match_addr_q)
                     & (ctrl_q[dmnc_pkg::CTRL_MATCH_USER] ?
                        user_map_strobe_o : exec_map_strobe_o); // [RULE_12]
  assign scope_trigger_o = match_hit
                           & ctrl_q[dmnc_pkg::CTRL_SOM_EN]; // [RULE_13]
  assign stop_on_match_irq = scope_trigger_o
                             & pin_q[dmnc_pkg::PIN_HALT_SW]; // [RULE_14]

  // Other NMI sources
  assign abort_rise = pin_q[dmnc_pkg::PIN_ABORT] & ~abort_prev_q;
  assign parity_fault_ack = ~pin_q[dmnc_pkg::PIN_PARITY_N] & parity_prev_q
                            & ctrl_q[dmnc_pkg::CTRL_PAR_EN]; // [RULE_17]
  assign step_fire = (step_cnt_q == 8'h01);
  assign nmi_src = stop_on_match_irq | abort_rise | parity_fault_ack
                   | step_fire;
  // Sources seen while the hold runs are dropped, not queued
  assign nmi_start = clk_en_i & nmi_src & (nmi_cnt_q == 6'h00); // [RULE_27]

  // Single-step delay, armed by the load pulse when stepping
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      step_cnt_q <= 8'h00;
    end else if (clk_en_i) begin
      if (ld_pulse && ctrl_q[dmnc_pkg::CTRL_STEP]) begin
        step_cnt_q <= 8'(STEP_DELAY); // [RULE_19]
      end else if (step_cnt_q != 8'h00) begin
        step_cnt_q <= step_cnt_q - 8'h01; // [RULE_19]
      end
    end
  end

  // NMI hold counter; the start cycle is the first of the hold
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nmi_cnt_q <= 6'h00;
    end else if (clk_en_i) begin
      if (nmi_start) begin
        nmi_cnt_q <= 6'(dmnc_pkg::NMI_HOLD_CYC - 1); // [RULE_16]
      end else if (nmi_cnt_q != 6'h00) begin
        nmi_cnt_q <= nmi_cnt_q - 6'h01; // [RULE_16] [RULE_27]
      end
    end
  end
  // Combinational path so the line falls in the source's own cycle
  assign nmi_n_o = ~(nmi_start | (nmi_cnt_q != 6'h00)); // [RULE_15]

  // Soft-interrupt detector: read, seven writes, read
  always_ff @(posedge core_clk_i) begin
    if (srst_i || bus_float_request_i) begin
      swi_cnt_q <= 4'h0; // [RULE_26]
    end else if (clk_en_i && shift_en && valid_mem_access_i) begin
      if (swi_cnt_q == 4'h0 || swi_cnt_q == 4'(dmnc_pkg::SWI_WRITES + 1)) begin
        swi_cnt_q <= rw_i ? 4'h1 : 4'h0;
      end else if (!rw_i) begin
        swi_cnt_q <= swi_cnt_q + 4'h1; // [RULE_26]
      end else begin
        swi_cnt_q <= 4'h1;
      end
    end
  end
  assign swi_detect = clk_en_i & shift_en & valid_mem_access_i & rw_i
                      & (swi_cnt_q == 4'(dmnc_pkg::SWI_WRITES + 1));

  // Force exec map until the vector fetch completes
  assign vec_fetch = valid_mem_access_i & rw_i
                     & (addr_i == dmnc_pkg::VEC_NMI_LO
                        || addr_i == dmnc_pkg::VEC_SWI_LO);
  always_ff @(posedge core_clk_i) begin
    if (any_rst) begin
      force_exec_q <= 1'b0;
    end else if (clk_en_i) begin
      if (mode == dmnc_pkg::MODE_DUAL && (nmi_start || (swi_detect
          && ctrl_q[dmnc_pkg::CTRL_BREAKPOINT_ENABLE]))) begin
        force_exec_q <= 1'b1; // [RULE_18] [RULE_26]
      end else if (vec_fetch) begin
        force_exec_q <= 1'b0;
      end
    end
  end

  // Origin flags; a status read clears them, a new event wins
  assign st_rd = clk_en_i & reg_rd_i & (reg_addr_i == dmnc_pkg::REG_STATUS);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      parity_flag_q <= 1'b0;
      abort_flag_line_o <= 1'b0;
      match_flag_line_o <= 1'b0;
      step_flag_line_o <= 1'b0;
    end else if (clk_en_i) begin
      parity_flag_q <= parity_fault_ack
                       | (parity_flag_q & ~st_rd); // [RULE_20]
      abort_flag_line_o <= abort_rise
                           | (abort_flag_line_o & ~st_rd); // [RULE_20]
      match_flag_line_o <= stop_on_match_irq
                           | (match_flag_line_o & ~st_rd); // [RULE_20]
      step_flag_line_o <= step_fire
                          | (step_flag_line_o & ~st_rd); // [RULE_20]
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          dmnc_pkg::REG_MATCH_ADDR: reg_rdata_o <= match_addr_q;
          dmnc_pkg::REG_CTRL: reg_rdata_o <= 16'(ctrl_q);
          dmnc_pkg::REG_LOAD: reg_rdata_o <= 16'(load_data_q);
          dmnc_pkg::REG_STATUS: begin
            reg_rdata_o[dmnc_pkg::ST_PARITY] <= parity_flag_q;
            reg_rdata_o[dmnc_pkg::ST_ABORT] <= abort_flag_line_o;
            reg_rdata_o[dmnc_pkg::ST_MATCH] <= match_flag_line_o;
            reg_rdata_o[dmnc_pkg::ST_STEP] <= step_flag_line_o;
            reg_rdata_o[dmnc_pkg::ST_SHIFT_OUT] <= shift_out_map_select;
            reg_rdata_o[dmnc_pkg::ST_FORCE] <= force_exec_q;
            reg_rdata_o[dmnc_pkg::ST_SERIAL] <= serial_q;
            reg_rdata_o[dmnc_pkg::ST_MODE +: 2] <= mode;
          end
          default: ;
        endcase
      end
    end
  end

  // Checks on the design's own outputs and internal state
  a_off_user_copy: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode == dmnc_pkg::MODE_OUT && !any_rst) |->
    (user_map_strobe_o == valid_mem_access_i) && !exec_map_strobe_o) // [RULE_01]
    else $error("off mode strobe mismatch");
  a_single_split: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode == dmnc_pkg::MODE_SINGLE && !any_rst && valid_mem_access_i) |->
    (exec_map_strobe_o == (addr_i >= 16'hF000))) // [RULE_02]
    else $error("single map split wrong");
  a_reset_low: assert property (@(posedge core_clk_i)
    any_rst |-> !user_map_strobe_o && !exec_map_strobe_o) // [RULE_04]
    else $error("strobe during reset");
  a_one_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ld_pulse |=> !ld_pulse) // [RULE_05]
    else $error("double load pulse");
  a_shift_step: assert property (@(posedge core_clk_i) disable iff (any_rst)
    (clk_en_i && shift_en && !ld_pulse && !nmi_start) |=>
    sr_q[dmnc_pkg::SR_W-1] == $past(sr_q[dmnc_pkg::SR_W-2])) // [RULE_07]
    else $error("shift did not advance");
  a_shift_hold: assert property (@(posedge core_clk_i) disable iff (any_rst)
    (clk_en_i && bus_float_request_i && !ld_pulse && !nmi_start) |=>
    $stable(sr_q)) // [RULE_24]
    else $error("shift during float");
  a_exec_rst_clr: assert property (@(posedge core_clk_i)
    exec_rst_q |=> sr_q == '0 && !serial_q) // [RULE_10]
    else $error("exec reset left state");
  a_trigger_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
    scope_trigger_o |-> ctrl_q[dmnc_pkg::CTRL_SOM_EN] && match_hit) // [RULE_13]
    else $error("trigger without enable");
  a_nmi_now: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && nmi_src) |-> !nmi_n_o) // [RULE_15]
    else $error("nmi not immediate");
  a_nmi_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (nmi_start && clk_en_i) |=> (!nmi_n_o || !clk_en_i) [*8]) // [RULE_16]
    else $error("nmi released early");
  a_nmi_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && nmi_cnt_q == 6'h01) |=> nmi_cnt_q == 6'h00) // [RULE_27]
    else $error("nmi hold extended");
  a_buf_dir: assert property (@(posedge core_clk_i)
    !data_buf_in_o |-> exec_map_bus_i && rw_i) // [RULE_21]
    else $error("buffer out without read");
  c_dual_user: cover property (@(posedge core_clk_i)
    mode == dmnc_pkg::MODE_DUAL && user_map_strobe_o);
  c_nmi_fire: cover property (@(posedge core_clk_i) nmi_start);
  c_swi_seen: cover property (@(posedge core_clk_i) swi_detect);
endmodule

// >>> shared/dmnc_pkg.sv
// Constants and types for the dual-map and NMI control core.
// Assumes a 10 MHz core clock and a 16-bit processor address bus.
package dmnc_pkg;
  // Register port map, word offsets on the 4-bit register address
  localparam logic [3:0] REG_MATCH_ADDR = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_LOAD = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  // Control register fields
  localparam int CTRL_SOM_EN = 0;
  localparam int CTRL_MATCH_USER = 1;
  localparam int CTRL_BREAKPOINT_ENABLE = 2;
  localparam int CTRL_PAR_EN = 3;
  localparam int CTRL_STEP = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] MATCH_RST = 16'h0000;
  localparam logic [3:0] LOAD_RST = 4'h0;
  // Status register fields
  localparam int ST_PARITY = 0;
  localparam int ST_ABORT = 1;
  localparam int ST_MATCH = 2;
  localparam int ST_STEP = 3;
  localparam int ST_SHIFT_OUT = 4;
  localparam int ST_FORCE = 5;
  localparam int ST_SERIAL = 6;
  localparam int ST_MODE = 8;
  // Map shift register and its loadable positions
  localparam int SR_W = 6;
  localparam int LD_POS_BIT4 = 1;
  localparam int LD_POS_BIT0 = 3;
  localparam int LD_POS_BIT1 = 4;
  localparam int LD_POS_BIT2 = 5;
  // Address ranges and vectors
  localparam logic [15:0] EXEC_LO = 16'hF000;
  localparam logic [15:0] BOARD_LO = 16'hF000;
  localparam logic [15:0] VEC_NMI_LO = 16'hFFFD;
  localparam logic [15:0] VEC_SWI_LO = 16'hFFFB;
  // Switch codes on the map-mode input
  localparam logic [1:0] SW_OUT = 2'h0;
  localparam logic [1:0] SW_SINGLE = 2'h1;
  localparam logic [1:0] SW_DUAL = 2'h2;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int NMI_HOLD_CYC = 32;
  localparam int STEP_DELAY_NS = 1000;
  localparam int STEP_DELAY_CYC = (STEP_DELAY_NS * CLK_MHZ) / 1000;
  localparam int SWI_WRITES = 7;
  // Synchronised pin vector layout
  localparam int PIN_W = 6;
  localparam int PIN_RESTART = 0;
  localparam int PIN_ABORT = 1;
  localparam int PIN_PARITY_N = 2;
  localparam int PIN_HALT_SW = 3;
  localparam int PIN_MODE = 4;
  localparam logic [5:0] PIN_RST = 6'h04;

  typedef enum logic [1:0] {MODE_OUT, MODE_SINGLE, MODE_DUAL} dmnc_mode_t;
endpackage

// >>> sim/dmnc_core_tb.sv
// Self-checking bench for the map-select and NMI core.
// Assumes the host model on the processor bus; step delay shortened to 3.
`timescale 1ns/1ps
module dmnc_core_tb;
  logic core_clk_i, srst_i, valid_mem_access, rw, flt, hlt, exb, hsw, rsw, rst, abt, par_n;
  logic [15:0] addr, reg_wdata, reg_rdata_o, rv;
  logic [3:0] reg_addr, ld;
  logic [1:0] mode_sw, e;
  logic [5:0] vec;
  logic reg_wr, reg_rd, user_o, exec_o, oe_o, nmi_n_o, trig_o, u;
  logic fa_o, fm_o, fs_o, bsel_o, buf_in_o;
  logic [31:0] seed;
  int bad_count, total_checks, n, w;

  dmnc_host_model host (.clk_i(core_clk_i), .vma_o(valid_mem_access), .addr_o(addr),
    .rw_o(rw));
  dmnc_core #(.STEP_DELAY(3)) dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .clk_en_i(1'b1), .valid_mem_access_i(valid_mem_access),
    .addr_i(addr), .rw_i(rw), .bus_grant_ack_i(1'b0),
    .bus_float_request_i(flt), .halt_i(hlt), .exec_map_bus_i(exb),
    .map_mode_switch_i(mode_sw), .halt_action_switch_i(hsw),
    .restart_target_switch_i(rsw), .restart_i(rst), .abort_i(abt),
    .parity_fault_n_i(par_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata_o), .user_map_strobe_o(user_o),
    .exec_map_strobe_o(exec_o), .map_strobe_oe_o(oe_o), .nmi_n_o(nmi_n_o),
    .scope_trigger_o(trig_o), .abort_flag_line_o(fa_o),
    .match_flag_line_o(fm_o), .step_flag_line_o(fs_o),
    .board_select_o(bsel_o), .data_buf_in_o(buf_in_o), .exec_reset_o(),
    .user_reset_o());

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask

  // Register port: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic bus(input logic [15:0] a, input logic r, input logic v);
    @(posedge core_clk_i);
    host.drive(a, r, v);
  endtask
  // Strobes sampled mid-cycle, once combinational paths have settled
  task automatic maps(input logic [1:0] x);
    @(negedge core_clk_i);
    check({14'h0, user_o, exec_o}, {14'h0, x}, "user/exec strobes");
  endtask

  // Fire one source, then count the low cycles; an abort re-fires mid-hold
  task automatic nmi_run(input int src);
    @(posedge core_clk_i);
    if (src == 0) abt <= 1'b1;
    if (src == 1) par_n <= 1'b0;
    if (src == 2) host.drive(16'hF123, 1'b1, 1'b1);
    w = 0;
    n = 0;
    @(negedge core_clk_i);
    while (nmi_n_o !== 1'b0 && w < 12) begin
      w++;
      @(negedge core_clk_i);
    end
    if (src == 2) check({15'h0, trig_o}, 16'h1, "scope trigger");
    while (nmi_n_o === 1'b0 && n < 40) begin
      n++;
      @(posedge core_clk_i);
      if (n == 1) host.drive(16'h2000, 1'b1, 1'b0);
      if (n == 8) abt <= 1'b0;
      if (n == 8) par_n <= 1'b1;
      if (n == 12) abt <= 1'b1;
      @(negedge core_clk_i);
    end
    @(posedge core_clk_i);
    abt <= 1'b0;
    check(n[15:0], 16'd32, "nmi low cycles");
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  initial begin
    cyc(5000);
    bad_count++;
    test_done;
  end

  initial begin
    seed = 32'h0000EA90;
    {srst_i, flt, hlt, exb, hsw, rsw, rst, abt, reg_wr, reg_rd} = 10'h200;
    {par_n, mode_sw, reg_addr, reg_wdata} = {1'b1, 2'h0, 4'h0, 16'h0000};
    bus(16'h1234, 1'b1, 1'b1);
    maps(2'b00);
    cyc(9);
    srst_i <= 1'b0;
    rd(dmnc_pkg::REG_CTRL, rv);
    check(rv, {11'h0, dmnc_pkg::CTRL_RST}, "ctrl reset");
    rd(4'hF, rv);
    check(rv, 16'h0000, "unmapped read");
    seed = lfsr(seed);
    wr(dmnc_pkg::REG_MATCH_ADDR, seed[15:0]);
    rd(dmnc_pkg::REG_MATCH_ADDR, rv);
    check(rv, seed[15:0], "match address readback");
    // Mode codes 3, 0, 1, 2; dual after srst_i routes all to exec
    for (int m = 3; m < 7; m++) begin
      @(posedge core_clk_i);
      mode_sw <= m[1:0];
      cyc(6);
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        rv = (i == 0) ? 16'hEFFF : (i == 1) ? 16'hF000 : seed[15:0];
        bus(rv, 1'b1, seed[16] | i < 2);
        e = (m % 4 == 1) ? ((rv >= 16'hF000) ? 2'b01 : 2'b10) : 2'b10;
        if (m % 4 == 2) e = 2'b01;
        maps(e & {2{seed[16] | i < 2}});
      end
    end
    // Load walk in dual mode: first load has only bit four set
    for (int j = 0; j < 5; j++) begin
      seed = lfsr(seed);
      ld = (j == 0) ? 4'h8 : seed[3:0];
      vec = {ld[2], ld[1], ld[0], 1'b0, ld[3], 1'b0};
      bus(16'h2000, 1'b0, 1'b1);
      wr(dmnc_pkg::REG_LOAD, {12'h000, ld});
      for (int k = 1; k < 9; k++) begin
        u = (k >= 2 && k <= 7) ? vec[7 - k] : 1'b0;
        maps({u, ~u});
      end
    end
    @(posedge core_clk_i);
    {rsw, rst} <= 2'b11;
    cyc(2);
    rst <= 1'b0;
    cyc(14);
    bus(16'h2000, 1'b1, 1'b1);
    maps(2'b10);
    nmi_run(0);
    check({15'h0, fa_o}, 16'h1, "abort flag");
    bus(16'h2000, 1'b1, 1'b1);
    maps(2'b01);
    bus(dmnc_pkg::VEC_NMI_LO, 1'b1, 1'b1);
    cyc(10);
    bus(16'h2000, 1'b1, 1'b1);
    maps(2'b10);
    @(posedge core_clk_i);
    {mode_sw, hsw} <= {dmnc_pkg::SW_SINGLE, 1'b1};
    wr(dmnc_pkg::REG_MATCH_ADDR, 16'hF123);
    wr(dmnc_pkg::REG_CTRL, 16'h0009);
    cyc(6);
    for (int s = 1; s < 3; s++) begin
      nmi_run(s);
      if (s == 2) check({15'h0, fm_o}, 16'h1, "match flag");
      rd(dmnc_pkg::REG_STATUS, rv);
      check({15'h0, rv[s == 1 ? 0 : 2]}, 16'h1, "status origin");
    end
    wr(dmnc_pkg::REG_CTRL, 16'h0010);
    wr(dmnc_pkg::REG_LOAD, 16'h0000);
    // Counter loads the cycle after the load pulse, fires at count one
    for (int k = 1; k < 5; k++) begin
      @(negedge core_clk_i);
      check({15'h0, nmi_n_o}, {15'h0, k != 4}, "step nmi");
    end
    cyc(34);
    check({15'h0, fs_o}, 16'h1, "step flag");
    bus(16'hF123, 1'b1, 1'b1);
    @(negedge core_clk_i);
    check({14'h0, trig_o, nmi_n_o}, 16'h1, "match disabled");
    for (int k = 0; k < 4; k++) begin
      bus(16'hF000, k[0], 1'b1);
      {flt, hlt, exb} <= {k[0], k[1], k[1]};
      @(negedge core_clk_i);
      check({15'h0, oe_o}, {15'h0, k == 0}, "strobe drive");
      check({14'h0, bsel_o, buf_in_o}, {14'h0, k[1], ~(k[1] & k[0])},
        "board select and buffers");
    end
    // Restart aimed at the executive side clears the serial flop
    @(posedge core_clk_i);
    {flt, hlt, exb, rsw, rst} <= 5'b00001;
    cyc(2);
    rst <= 1'b0;
    cyc(6);
    rd(dmnc_pkg::REG_STATUS, rv);
    check({15'h0, rv[6]}, 16'h0, "serial after exec reset");
    test_done;
  end
endmodule

// >>> sim/dmnc_host_model.sv
// Host processor bus model for the map-select core: access strobe,
// address and direction. Assumes drive() is called just after an edge.
`timescale 1ns/1ps
module dmnc_host_model (
  input wire logic clk_i,
  output logic vma_o,
  output logic [15:0] addr_o,
  output logic rw_o
);
  logic [15:0] a_q;
  logic r_q;
  logic [15:0] spin_q;

  // Request held from one edge until the next call changes it
  task automatic drive(input logic [15:0] a, input logic r, input logic v);
    a_q <= a;
    r_q <= r;
    vma_o <= v;
  endtask

  initial begin
    a_q = 16'h0000;
    r_q = 1'b1;
    vma_o = 1'b0;
    spin_q = 16'hA5A5;
  end

  // Idle bus wanders so stale addresses cannot pass for valid ones
  always_ff @(posedge clk_i) begin
    spin_q <= spin_q + 16'h3B1D;
  end
  assign addr_o = vma_o ? a_q : spin_q;
  assign rw_o = vma_o ? r_q : spin_q[0];
endmodule
